/* design/rf_tx_driver_control.sv */
// Behaviour
// RULE1 - both antenna pins carry the carrier shaped by the transmit envelope
// RULE2 - carrier is crystal clock halved; an inverted copy is also selectable
// RULE3 - envelope high: p array takes the steady p conductance register
// RULE4 - envelope low: p array takes the modulation p conductance register
// RULE5 - envelope high: n array takes the steady 4-bit n field
// RULE6 - envelope low: n array takes the modulation 4-bit n field
// RULE7 - with one driver on, both drivers use the same conductance settings
// RULE8 - driver off: both arrays take the all-off setting whatever else
// RULE9 - drive b steady wave: steady conductance, carrier or inverse only
// RULE10 - pin waveforms follow the pin control register
// RULE11 - rate, framing and driver source follow the mode and select regs
// RULE12 - the uart frames and checks data up to 848 kBd
// RULE13 - the uart makes bit-oriented and byte-oriented frames
// RULE14 - the uart detects errors with parity and crc
// RULE15 - an outside modem may use the modem input and output pins
// RULE16 - forced full-depth ask pulls a pin low while envelope is low
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module rf_tx_driver_control #(
  parameter int P_W = 6,
  parameter int N_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic xtal_clk,
  input wire logic ext_modem_in,
  output logic ext_modem_out,
  output logic antenna_drive_a,
  output logic antenna_drive_b,
  output logic [P_W-1:0] p_array_setting_a,
  output logic [N_W-1:0] n_array_setting_a,
  output logic [P_W-1:0] p_array_setting_b,
  output logic [N_W-1:0] n_array_setting_b
);
  typedef enum logic {R_IDLE = 1'b0, R_RUN = 1'b1} rstate_t;

  frame_if fr ();

  logic [7:0] pin_ctl_r, pin_ctl_nxt, n_cond_r, n_cond_nxt;
  logic [5:0] rate_fr_r, rate_fr_nxt;
  logic [1:0] drv_sel_r, drv_sel_nxt;
  logic [P_W-1:0] p_steady_r, p_steady_nxt, p_mod_r, p_mod_nxt;
  logic [7:0] tx_byte_r, tx_byte_nxt;
  logic tx_go_r, tx_go_nxt, crc_clr_r, crc_clr_nxt;
  logic pready_nxt, pslverr_nxt;
  logic [31:0] prdata_nxt;
  logic acc, wr, rd;
  logic xs1_r, xs2_r, xs3_r, mi1_r, mi2_r, carrier_r;
  logic env_r, env_nxt;
  rstate_t rst_r, rst_nxt;
  logic [15:0] rcnt_r, rcnt_nxt, rcrc_r, rcrc_nxt;
  logic [3:0] ridx_r, ridx_nxt;
  logic [7:0] rsh_r, rsh_nxt, rdata_r, rdata_nxt;
  logic rpar_r, rpar_nxt, rvalid_r, rvalid_nxt, perr_r, perr_nxt;
  logic byte_done, par_bad;
  logic pin_a_nxt, pin_b_nxt;
  logic [P_W-1:0] pa_nxt, pb_nxt;
  logic [N_W-1:0] na_nxt, nb_nxt;

  // pin level for one driver from its control bits
  function automatic logic pin_level(input logic en, input logic force_ask,
                                     input logic inv_on, input logic inv_off,
                                     input logic steady, input logic env,
                                     input logic carrier);
    if (!en) begin
      pin_level = 1'b0;
    end else if (steady || env) begin
      pin_level = inv_on ? ~carrier : carrier;
    end else if (force_ask) begin
      pin_level = 1'b0;
    end else begin
      pin_level = inv_off ? ~carrier : carrier;
    end
  endfunction

  bit_framer u_framer (
    .pclk(pclk),
    .presetn(presetn),
    .f(fr.framer)
  );

  // framer start and byte come from the tx data write, the rest from the rate/framing register
  assign fr.start = tx_go_r;
  assign fr.data = tx_byte_r;
  assign fr.byte_mode = rate_fr_r[rf_tx_pkg::RF_BYTE_MODE]; // RULE11
  assign fr.parity_en = rate_fr_r[rf_tx_pkg::RF_PARITY];
  assign fr.crc_clear = crc_clr_r;
  assign fr.rate = rate_fr_r[rf_tx_pkg::RF_RATE_LO +: 2]; // RULE12

  // apb decode: one wait state, effects at the completing edge
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;

  always_comb begin
    pin_ctl_nxt = pin_ctl_r;
    rate_fr_nxt = rate_fr_r;
    drv_sel_nxt = drv_sel_r;
    p_steady_nxt = p_steady_r;
    p_mod_nxt = p_mod_r;
    n_cond_nxt = n_cond_r;
    tx_byte_nxt = tx_byte_r;
    tx_go_nxt = 1'b0;
    crc_clr_nxt = 1'b0;
    pready_nxt = psel && penable && !pready;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata;
    if (wr) begin
      case (paddr)
        rf_tx_pkg::OFS_PIN_CONTROL: pin_ctl_nxt = pwdata[7:0]; // RULE10
        rf_tx_pkg::OFS_RATE_FRAMING: begin
          rate_fr_nxt = pwdata[5:0] & 6'h2F;
          crc_clr_nxt = pwdata[rf_tx_pkg::RF_CRC_CLEAR];
        end
        rf_tx_pkg::OFS_DRIVER_SELECT: drv_sel_nxt = pwdata[1:0];
        rf_tx_pkg::OFS_P_STEADY: p_steady_nxt = pwdata[P_W-1:0];
        rf_tx_pkg::OFS_P_MOD: p_mod_nxt = pwdata[P_W-1:0];
        rf_tx_pkg::OFS_N_COND: n_cond_nxt = pwdata[7:0];
        rf_tx_pkg::OFS_TX_DATA: begin
          tx_byte_nxt = pwdata[7:0];
          tx_go_nxt = !fr.busy; // ignored while a byte is in flight
        end
        default: ;
      endcase
    end
    if (pready_nxt) begin
      prdata_nxt = 32'h0000_0000;
      case (paddr)
        rf_tx_pkg::OFS_PIN_CONTROL: prdata_nxt[7:0] = pin_ctl_r;
        rf_tx_pkg::OFS_RATE_FRAMING: prdata_nxt[5:0] = rate_fr_r;
        rf_tx_pkg::OFS_DRIVER_SELECT: prdata_nxt[1:0] = drv_sel_r;
        rf_tx_pkg::OFS_P_STEADY: prdata_nxt[P_W-1:0] = p_steady_r;
        rf_tx_pkg::OFS_P_MOD: prdata_nxt[P_W-1:0] = p_mod_r;
        rf_tx_pkg::OFS_N_COND: prdata_nxt[7:0] = n_cond_r;
        rf_tx_pkg::OFS_TX_DATA: prdata_nxt[7:0] = tx_byte_r;
        rf_tx_pkg::OFS_STATUS: begin
          prdata_nxt[rf_tx_pkg::ST_BUSY] = fr.busy;
          prdata_nxt[rf_tx_pkg::ST_RX_VALID] = rvalid_r;
          prdata_nxt[rf_tx_pkg::ST_PAR_ERR] = perr_r;
          prdata_nxt[rf_tx_pkg::ST_CRC_OK] =
            (rcrc_r == rf_tx_pkg::CRC_GOOD_RESIDUE); // RULE14
        end
        rf_tx_pkg::OFS_RX_DATA: prdata_nxt[7:0] = rdata_r;
        rf_tx_pkg::OFS_CRC: prdata_nxt = {rcrc_r, fr.crc};
        default: pslverr_nxt = 1'b1;
      endcase
    end
  end

  // receive: byte frames from the outside modem, parity and crc checked
  assign byte_done = (rst_r == R_RUN) && (rcnt_r == 16'h0000) &&
    ((ridx_r == 4'h8 && !rate_fr_r[rf_tx_pkg::RF_PARITY]) ||
     ridx_r == 4'h9);
  assign par_bad = byte_done && (ridx_r == 4'h9) && !(rpar_r ^ mi2_r);

  always_comb begin
    rst_nxt = rst_r;
    rcnt_nxt = rcnt_r;
    ridx_nxt = ridx_r;
    rsh_nxt = rsh_r;
    rpar_nxt = rpar_r;
    rdata_nxt = rdata_r;
    rcrc_nxt = crc_clr_r ? rf_tx_pkg::CRC_PRESET : rcrc_r;
    case (rst_r)
      R_IDLE: begin
        if (rate_fr_r[rf_tx_pkg::RF_RX_EN] && !mi2_r) begin // RULE15
          rst_nxt = R_RUN;
          rcnt_nxt = rf_tx_pkg::bit_period(fr.rate) >> 1;
          ridx_nxt = 4'h0;
          rpar_nxt = 1'b0;
        end
      end
      default: begin
        if (rcnt_r != 16'h0000) begin
          rcnt_nxt = rcnt_r - 16'h0001;
        end else begin
          rcnt_nxt = rf_tx_pkg::bit_period(fr.rate) - 16'h0001;
          ridx_nxt = ridx_r + 4'h1;
          if (ridx_r == 4'h0 && mi2_r) begin
            rst_nxt = R_IDLE; // glitch, not a start bit
          end else if (ridx_r != 4'h0 && ridx_r <= 4'h8) begin
            rsh_nxt = {mi2_r, rsh_r[7:1]};
            rpar_nxt = rpar_r ^ mi2_r;
            rcrc_nxt = rf_tx_pkg::crc_step(rcrc_nxt, mi2_r); // RULE14
          end
          if (byte_done) begin
            rst_nxt = R_IDLE;
            rdata_nxt = (ridx_r == 4'h8) ? {mi2_r, rsh_r[7:1]} : rsh_r;
          end
        end
      end
    endcase
    // sticky flags: a new event wins over the clear in the same cycle
    rvalid_nxt = byte_done ||
      (rvalid_r && !(rd && paddr == rf_tx_pkg::OFS_RX_DATA));
    perr_nxt = par_bad || (perr_r && !(wr && paddr == rf_tx_pkg::OFS_STATUS
      && pwdata[rf_tx_pkg::ST_PAR_ERR])); // RULE14
  end

  // envelope source: own framer, outside modem or fixed levels
  always_comb begin
    case (drv_sel_r) // RULE11
      rf_tx_pkg::ENV_FRAMER: env_nxt = fr.bit_out; // RULE13
      rf_tx_pkg::ENV_MODEM: env_nxt = mi2_r; // RULE15
      rf_tx_pkg::ENV_HIGH: env_nxt = 1'b1;
      default: env_nxt = 1'b0;
    endcase
  end

  // driver pins and conductance arrays; one register set feeds both drivers
  always_comb begin
    pin_a_nxt = pin_level(pin_ctl_r[rf_tx_pkg::PC_A_ON],
      pin_ctl_r[rf_tx_pkg::PC_FORCE], pin_ctl_r[rf_tx_pkg::PC_A_INV_ON],
      pin_ctl_r[rf_tx_pkg::PC_A_INV_OFF], 1'b0, env_r, carrier_r); // RULE1
    pin_b_nxt = pin_level(pin_ctl_r[rf_tx_pkg::PC_B_ON],
      pin_ctl_r[rf_tx_pkg::PC_FORCE], pin_ctl_r[rf_tx_pkg::PC_B_INV_ON],
      pin_ctl_r[rf_tx_pkg::PC_B_INV_OFF], pin_ctl_r[rf_tx_pkg::PC_B_STEADY],
      env_r, carrier_r); // RULE16
    pa_nxt = env_r ? p_steady_r : p_mod_r; // RULE3 RULE4
    na_nxt = env_r ? n_cond_r[rf_tx_pkg::N_STEADY_LO +: N_W] // RULE5
                   : n_cond_r[rf_tx_pkg::N_MOD_LO +: N_W]; // RULE6
    pb_nxt = (env_r || pin_ctl_r[rf_tx_pkg::PC_B_STEADY]) ? p_steady_r
             : p_mod_r; // RULE9 RULE7
    nb_nxt = (env_r || pin_ctl_r[rf_tx_pkg::PC_B_STEADY])
             ? n_cond_r[rf_tx_pkg::N_STEADY_LO +: N_W]
             : n_cond_r[rf_tx_pkg::N_MOD_LO +: N_W];
    if (!pin_ctl_r[rf_tx_pkg::PC_A_ON]) begin // RULE8
      pa_nxt = '0;
      na_nxt = '0;
    end
    if (!pin_ctl_r[rf_tx_pkg::PC_B_ON]) begin // RULE8
      pb_nxt = '0;
      nb_nxt = '0;
    end
  end

  // all registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ctl_r <= rf_tx_pkg::PIN_CONTROL_RST;
      rate_fr_r <= rf_tx_pkg::RATE_FRAMING_RST;
      drv_sel_r <= rf_tx_pkg::DRIVER_SELECT_RST;
      p_steady_r <= P_W'(rf_tx_pkg::P_STEADY_RST);
      p_mod_r <= P_W'(rf_tx_pkg::P_MOD_RST);
      n_cond_r <= rf_tx_pkg::N_COND_RST;
      tx_byte_r <= 8'h00;
      tx_go_r <= 1'b0;
      crc_clr_r <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      xs1_r <= 1'b0;
      xs2_r <= 1'b0;
      xs3_r <= 1'b0;
      mi1_r <= 1'b1;
      mi2_r <= 1'b1;
      carrier_r <= 1'b0;
      env_r <= 1'b1;
      rst_r <= R_IDLE;
      rcnt_r <= 16'h0000;
      rcrc_r <= rf_tx_pkg::CRC_PRESET;
      ridx_r <= 4'h0;
      rsh_r <= 8'h00;
      rpar_r <= 1'b0;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      perr_r <= 1'b0;
      ext_modem_out <= 1'b1;
      antenna_drive_a <= 1'b0;
      antenna_drive_b <= 1'b0;
      p_array_setting_a <= '0;
      n_array_setting_a <= '0;
      p_array_setting_b <= '0;
      n_array_setting_b <= '0;
    end else begin
      pin_ctl_r <= pin_ctl_nxt;
      rate_fr_r <= rate_fr_nxt;
      drv_sel_r <= drv_sel_nxt;
      p_steady_r <= p_steady_nxt;
      p_mod_r <= p_mod_nxt;
      n_cond_r <= n_cond_nxt;
      tx_byte_r <= tx_byte_nxt;
      tx_go_r <= tx_go_nxt;
      crc_clr_r <= crc_clr_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      prdata <= prdata_nxt;
      xs1_r <= xtal_clk;
      xs2_r <= xs1_r;
      xs3_r <= xs2_r;
      mi1_r <= ext_modem_in;
      mi2_r <= mi1_r;
      carrier_r <= carrier_r ^ (xs2_r && !xs3_r); // RULE2
      env_r <= env_nxt;
      rst_r <= rst_nxt;
      rcnt_r <= rcnt_nxt;
      rcrc_r <= rcrc_nxt;
      ridx_r <= ridx_nxt;
      rsh_r <= rsh_nxt;
      rpar_r <= rpar_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      perr_r <= perr_nxt;
      ext_modem_out <= fr.bit_out; // RULE15
      antenna_drive_a <= pin_a_nxt;
      antenna_drive_b <= pin_b_nxt;
      p_array_setting_a <= pa_nxt;
      n_array_setting_a <= na_nxt;
      p_array_setting_b <= pb_nxt;
      n_array_setting_b <= nb_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_carrier_halves;
    $rose(xs2_r) |=> ##1 (carrier_r != $past(carrier_r, 2));
  endproperty
  a_carrier_halves: assert property (p_carrier_halves) // RULE2
    else $error("carrier did not toggle on crystal edge");

  property p_off_arrays;
    !pin_ctl_r[0] |=> (p_array_setting_a == '0 && n_array_setting_a == '0);
  endproperty
  a_off_arrays: assert property (p_off_arrays) // RULE8
    else $error("driver a off but arrays not all off");

  property p_steady_p;
    (pin_ctl_r[0] && env_r) |=> p_array_setting_a == $past(p_steady_r);
  endproperty
  a_steady_p: assert property (p_steady_p) // RULE3
    else $error("p array not steady value with envelope high");

  property p_mod_p;
    (pin_ctl_r[0] && !env_r) |=> p_array_setting_a == $past(p_mod_r);
  endproperty
  a_mod_p: assert property (p_mod_p) // RULE4
    else $error("p array not modulation value with envelope low");

  property p_steady_n;
    (pin_ctl_r[0] && env_r) |=> n_array_setting_a == $past(n_cond_r[3:0]);
  endproperty
  a_steady_n: assert property (p_steady_n) // RULE5
    else $error("n array not steady field with envelope high");

  property p_mod_n;
    (pin_ctl_r[0] && !env_r) |=> n_array_setting_a == $past(n_cond_r[7:4]);
  endproperty
  a_mod_n: assert property (p_mod_n) // RULE6
    else $error("n array not modulation field with envelope low");

  sequence s_b_steady;
    pin_ctl_r[1] && pin_ctl_r[5];
  endsequence
  property p_b_steady;
    s_b_steady |=> (n_array_setting_b == $past(n_cond_r[3:0]) &&
      antenna_drive_b == ($past(carrier_r) ^ $past(pin_ctl_r[6])));
  endproperty
  a_b_steady: assert property (p_b_steady) // RULE9
    else $error("drive b steady wave not honoured");

  property p_one_driver;
    (pin_ctl_r[1] && !pin_ctl_r[0] && !pin_ctl_r[5] && !env_r)
      |=> p_array_setting_b == $past(p_mod_r);
  endproperty
  a_one_driver: assert property (p_one_driver) // RULE7
    else $error("single driver b lacks shared conductance");

  property p_full_ask;
    (pin_ctl_r[0] && pin_ctl_r[2] && !env_r) |=> !antenna_drive_a;
  endproperty
  a_full_ask: assert property (p_full_ask) // RULE16
    else $error("forced ask pin not low while envelope low");
endmodule

/* design/rf_tx_pkg.sv */
package rf_tx_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_PIN_CONTROL = 8'h00;
  localparam logic [7:0] OFS_RATE_FRAMING = 8'h04;
  localparam logic [7:0] OFS_DRIVER_SELECT = 8'h08;
  localparam logic [7:0] OFS_P_STEADY = 8'h0C;
  localparam logic [7:0] OFS_P_MOD = 8'h10;
  localparam logic [7:0] OFS_N_COND = 8'h14;
  localparam logic [7:0] OFS_TX_DATA = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_RX_DATA = 8'h20;
  localparam logic [7:0] OFS_CRC = 8'h24;
  // tx_pin_control fields
  localparam int PC_A_ON = 0;
  localparam int PC_B_ON = 1;
  localparam int PC_FORCE = 2;
  localparam int PC_A_INV_ON = 3;
  localparam int PC_A_INV_OFF = 4;
  localparam int PC_B_STEADY = 5;
  localparam int PC_B_INV_ON = 6;
  localparam int PC_B_INV_OFF = 7;
  // tx_rate_framing fields
  localparam int RF_RATE_LO = 0;
  localparam int RF_BYTE_MODE = 2;
  localparam int RF_PARITY = 3;
  localparam int RF_CRC_CLEAR = 4;
  localparam int RF_RX_EN = 5;
  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_RX_VALID = 1;
  localparam int ST_PAR_ERR = 2;
  localparam int ST_CRC_OK = 3;
  // n_side_conductance fields
  localparam int N_STEADY_LO = 0;
  localparam int N_MOD_LO = 4;
  // envelope sources in tx_driver_select
  localparam logic [1:0] ENV_FRAMER = 2'h0;
  localparam logic [1:0] ENV_MODEM = 2'h1;
  localparam logic [1:0] ENV_HIGH = 2'h2;
  // reset values and crc constants
  localparam logic [7:0] PIN_CONTROL_RST = 8'h00;
  localparam logic [5:0] RATE_FRAMING_RST = 6'h04;
  localparam logic [1:0] DRIVER_SELECT_RST = 2'h0;
  localparam logic [5:0] P_STEADY_RST = 6'h3F;
  localparam logic [5:0] P_MOD_RST = 6'h20;
  localparam logic [7:0] N_COND_RST = 8'h88;
  localparam logic [15:0] CRC_PRESET = 16'h6363;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_GOOD_RESIDUE = 16'h0000;
  // timing: fastest link is 848 kBd on a 200 MHz clock
  localparam int CLK_HZ = 200_000_000;
  localparam int MAX_BAUD = 848_000;
  localparam int BIT_CYC_FAST = CLK_HZ / MAX_BAUD;

  // cycles per bit for rate code 0..3 (106, 212, 424, 848 kBd)
  function automatic logic [15:0] bit_period(input logic [1:0] rate);
    bit_period = 16'(BIT_CYC_FAST) << (2'h3 - rate);
  endfunction

  // one bit of the reflected crc, lsb first
  function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                           input logic b);
    crc_step = (crc[0] ^ b) ? ((crc >> 1) ^ CRC_POLY) : (crc >> 1);
  endfunction
endpackage

/* design/frame_if.sv */
`timescale 1ns/1ps
interface frame_if;
  logic start;
  logic [7:0] data;
  logic byte_mode;
  logic parity_en;
  logic crc_clear;
  logic [1:0] rate;
  logic busy;
  logic bit_out;
  logic [15:0] crc;
  modport framer (input start, data, byte_mode, parity_en, crc_clear, rate,
                  output busy, bit_out, crc);
  modport ctrl (output start, data, byte_mode, parity_en, crc_clear, rate,
                input busy, bit_out, crc);
endinterface

/* design/bit_framer.sv */
`timescale 1ns/1ps
module bit_framer (
  input wire logic pclk,
  input wire logic presetn,
  frame_if.framer f
);
  typedef enum logic [2:0] {
    F_IDLE = 3'b000, F_START = 3'b001, F_DATA = 3'b011,
    F_PAR = 3'b010, F_STOP = 3'b110
  } fstate_t;

  fstate_t st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt, crc_r, crc_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic bit_r, bit_nxt, par_r, par_nxt, bm_r, bm_nxt, pe_r, pe_nxt;

  // serialiser: byte framing adds start and stop bits, and odd parity when parity is enabled
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    crc_nxt = crc_r;
    idx_nxt = idx_r;
    sh_nxt = sh_r;
    bit_nxt = bit_r;
    par_nxt = par_r;
    bm_nxt = bm_r;
    pe_nxt = pe_r;
    case (st_r)
      F_IDLE: begin
        bit_nxt = 1'b1;
        if (f.start) begin // RULE13
          sh_nxt = f.data;
          bm_nxt = f.byte_mode;
          pe_nxt = f.parity_en;
          cnt_nxt = rf_tx_pkg::bit_period(f.rate) - 16'h0001;
          idx_nxt = 3'h0;
          par_nxt = 1'b0;
          if (f.byte_mode) begin
            st_nxt = F_START;
            bit_nxt = 1'b0;
          end else begin
            st_nxt = F_DATA;
            bit_nxt = f.data[0];
            par_nxt = f.data[0];
            crc_nxt = rf_tx_pkg::crc_step(crc_r, f.data[0]);
          end
        end
      end
      default: begin
        if (cnt_r != 16'h0000) begin
          cnt_nxt = cnt_r - 16'h0001;
        end else begin
          cnt_nxt = rf_tx_pkg::bit_period(f.rate) - 16'h0001;
          case (st_r)
            F_START: begin
              st_nxt = F_DATA;
              bit_nxt = sh_r[0];
              par_nxt = sh_r[0];
              crc_nxt = rf_tx_pkg::crc_step(crc_r, sh_r[0]); // RULE14
            end
            F_DATA: begin
              if (idx_r == 3'h7) begin
                if (bm_r && pe_r) begin
                  st_nxt = F_PAR;
                  bit_nxt = ~par_r; // RULE14
                end else if (bm_r) begin
                  st_nxt = F_STOP;
                  bit_nxt = 1'b1;
                end else begin
                  st_nxt = F_IDLE;
                  bit_nxt = 1'b1;
                end
              end else begin
                idx_nxt = idx_r + 3'h1;
                sh_nxt = sh_r >> 1;
                bit_nxt = sh_r[1];
                par_nxt = par_r ^ sh_r[1];
                crc_nxt = rf_tx_pkg::crc_step(crc_r, sh_r[1]);
              end
            end
            F_PAR: begin
              st_nxt = F_STOP;
              bit_nxt = 1'b1;
            end
            default: begin
              st_nxt = F_IDLE;
              bit_nxt = 1'b1;
            end
          endcase
        end
      end
    endcase
    if (f.crc_clear) begin
      crc_nxt = rf_tx_pkg::CRC_PRESET;
    end
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= F_IDLE;
      cnt_r <= 16'h0000;
      crc_r <= rf_tx_pkg::CRC_PRESET;
      idx_r <= 3'h0;
      sh_r <= 8'h00;
      bit_r <= 1'b1;
      par_r <= 1'b0;
      bm_r <= 1'b0;
      pe_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      crc_r <= crc_nxt;
      idx_r <= idx_nxt;
      sh_r <= sh_nxt;
      bit_r <= bit_nxt;
      par_r <= par_nxt;
      bm_r <= bm_nxt;
      pe_r <= pe_nxt;
    end
  end

  assign f.busy = (st_r != F_IDLE);
  assign f.bit_out = bit_r;
  assign f.crc = crc_r;
endmodule

/* tb/rf_far_side.sv */
`timescale 1ns/1ps
module rf_far_side (
  output logic xtal_clk,
  input wire logic ext_modem_out,
  output logic ext_modem_in
);
  // 27.12 MHz crystal, unrelated in phase to the bus clock
  initial begin
    xtal_clk = 1'b0;
    #1.3;
    forever #18.437 xtal_clk = ~xtal_clk;
  end
  // outside modem echoes the serial stream back to the receiver
  assign ext_modem_in = ext_modem_out;
endmodule

/* tb/rf_tx_driver_control_test.sv */
`timescale 1ns/1ps
module rf_tx_driver_control_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic xtal_clk, ext_modem_in, ext_modem_out, drive_a, drive_b;
  logic [5:0] pa, pb;
  logic [3:0] na, nb;
  int fails = 0;
  int tests_run = 0;
  rf_tx_driver_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xtal_clk(xtal_clk), .ext_modem_in(ext_modem_in),
    .ext_modem_out(ext_modem_out), .antenna_drive_a(drive_a),
    .antenna_drive_b(drive_b), .p_array_setting_a(pa),
    .n_array_setting_a(na), .p_array_setting_b(pb), .n_array_setting_b(nb));
  rf_far_side far (.xtal_clk(xtal_clk), .ext_modem_out(ext_modem_out),
    .ext_modem_in(ext_modem_in));
  // 200 MHz bus clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer, bounded wait for pready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    if (n >= 50) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // array settings after a change has reached the pins
  task automatic arr(input logic [19:0] e);
    cyc(3);
    chk(32'({pa, na, pb, nb}), 32'(e));
  endtask
  // reset values, then an unmapped read
  task automatic t_reset;
    logic [31:0] rv [6] = '{32'h00, 32'h04, 32'h00, 32'h3F, 32'h20, 32'h88};
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(q, rv[i]);
    end
    apb(1'b0, 8'h30, 32'h0);
    chk({q[30:0], err}, 32'h1);
    $display("test reset done");
  endtask
  // conductance choice by envelope, enables and steady wave
  task automatic t_cond;
    apb(1'b1, 8'h0C, 32'h15);
    apb(1'b1, 8'h10, 32'h2A);
    apb(1'b1, 8'h14, 32'h93);
    apb(1'b1, 8'h00, 32'h03);
    apb(1'b1, 8'h08, 32'h2);
    arr({6'h15, 4'h3, 6'h15, 4'h3});
    apb(1'b1, 8'h08, 32'h3);
    arr({6'h2A, 4'h9, 6'h2A, 4'h9});
    apb(1'b1, 8'h00, 32'h23);
    arr({6'h2A, 4'h9, 6'h15, 4'h3});
    apb(1'b1, 8'h00, 32'h02);
    arr({6'h00, 4'h0, 6'h2A, 4'h9});
    apb(1'b1, 8'h00, 32'h00);
    arr(20'h0);
    $display("test conductance done");
  endtask
  // forced low pins, then carrier and its inverse
  task automatic t_pins;
    int hi;
    int tg;
    logic last;
    apb(1'b1, 8'h00, 32'h07);
    cyc(3);
    hi = 0;
    repeat (60) begin
      @(posedge pclk);
      hi += int'(drive_a === 1'b1) + int'(drive_b === 1'b1);
    end
    chk(32'(hi), 32'h0);
    apb(1'b1, 8'h00, 32'h43);
    apb(1'b1, 8'h08, 32'h2);
    cyc(3);
    hi = 0;
    tg = 0;
    last = drive_a;
    repeat (200) begin
      @(posedge pclk);
      hi += int'(drive_a !== ~drive_b);
      tg += int'(drive_a !== last);
      last = drive_a;
    end
    chk(32'(hi), 32'h0);
    chk(32'(tg > 24 && tg < 30), 32'h1);
    $display("test pins done");
  endtask
  // byte frame out, echoed by the far side and received; the echo also
  // serves as envelope so the a-side p array follows the serial stream
  task automatic t_frame;
    logic [10:0] fr = {1'b1, 1'b1, 8'hA5, 1'b0};
    logic [7:0] bm = 8'h3C;
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b1, 8'h04, 32'h2F);
    apb(1'b1, 8'h18, 32'hA5);
    cyc(rf_tx_pkg::BIT_CYC_FAST / 2 + 2);
    for (int i = 0; i < 11; i++) begin
      chk(32'(ext_modem_out), 32'(fr[i]));
      chk(32'(pa), fr[i] ? 32'h15 : 32'h2A);
      cyc(rf_tx_pkg::BIT_CYC_FAST);
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk(32'(q[2:0]), 32'h2);
    apb(1'b0, 8'h20, 32'h0);
    chk(q, 32'hA5);
    // crc clear pulse, then a bit-oriented frame at the next lower rate
    apb(1'b1, 8'h04, 32'h12);
    apb(1'b0, 8'h24, 32'h0);
    chk(q, {rf_tx_pkg::CRC_PRESET, rf_tx_pkg::CRC_PRESET});
    apb(1'b1, 8'h18, 32'h3C);
    cyc(rf_tx_pkg::BIT_CYC_FAST + 2);
    for (int i = 0; i < 8; i++) begin
      chk(32'(ext_modem_out), 32'(bm[i]));
      cyc(2 * rf_tx_pkg::BIT_CYC_FAST);
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk(32'(q[3:0]), 32'h0);
    $display("test frame done");
  endtask
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_cond;
    t_pins;
    t_frame;
    results;
  end
  // watchdog against a hang
  initial begin
    #100000;
    fails++;
    results;
  end
endmodule
